// file: ssds_top.sv
/*
 * SPI target unit with byte DMA and a CPU/unit semaphore, AXI4-Lite regs.
 * Assumes the byte RAM port acks each request within about 30 clocks and
 * that SCK runs no faster than one eighth of sys_clk.
 */
// What this block does
// - All four CPOL/CPHA modes via config
// - Separate transmit read and receive write DMA
// - Past transmit count, send overrun fill
// - Completion event waits for DMA idle
// - Release without CPU ownership is ignored
// - Semaphore never blocks CPU register access
// - Enable hands semaphore to CPU silently
// - Acquire while CPU owns: event at once
// - Failed take: ignore transaction, send fill
// - Same-cycle contention goes to CPU
// - Granted: store MOSI, send transmit bytes
// - Granted end: release, raise completion event
// - Repeat transactions reuse unchanged pointers
// - Shortcut hands semaphore to CPU after completion
// - Acquire during unit ownership stays pending
// - Only one acquire served after completion
// - Receive past maximum: overflow, discard bytes
// - Transmit past maximum: exhausted flag, fill
// - Amount counts updated at completion only
// - Receive full event at maximum count
// - MISO undriven while not selected
// - Ignored fill character from register
`timescale 1ns/100ps
module ssds_top
	import ssds_pkg::*;
#(
	parameter int CNT_W = 10 // Width of max and amount counts
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// AXI4-Lite slave
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// SPI pins
	input  wire logic        csn_n_i,
	input  wire logic        sck_i,
	input  wire logic        mosi_i,
	output logic             miso_o,
	output logic             miso_oe_o,
	// Byte RAM port
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic [31:0]      mem_addr_o,
	output logic [7:0]       mem_wdata_o,
	input  wire logic [7:0]  mem_rdata_i,
	input  wire logic        mem_ack_i
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Word match on the register window
	function automatic logic hit(input logic [31:0] a, input logic [11:0] o);
		hit = (a[11:2] == o[11:2]);
	endfunction : hit
	// Bit reversal, keeps the shifter always msb-out
	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = b[7-i];
		end
	endfunction : rev8
	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8+:8] = s[i] ? n[i*8+:8] : o[i*8+:8];
		end
	endfunction : merge

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic             enable_q, en_prev_q;     // Unit enable and its history
	logic             short_q;                 // Completion-to-acquire shortcut
	logic [2:0]       cfg_q;                   // Order, phase, polarity
	logic [7:0]       ign_chr_q, ovr_chr_q;    // Fill characters
	logic [31:0]      rx_ptr_q, tx_ptr_q;      // Buffer pointers
	logic [CNT_W-1:0] rx_max_q, tx_max_q;      // Max counts
	logic [CNT_W-1:0] rx_amt_q, tx_amt_q;      // Last granted amounts
	logic             ev_end_q, ev_full_q, ev_acq_q; // Sticky events
	logic             ovr_rd_q, ovr_fl_q;      // Sticky status
	ssds_sem_e        sem_q;                   // Semaphore owner
	logic             acq_pend_q;              // Acquire waiting on unit
	ssds_xfer_e       xs_q;                    // Transaction state
	// Bus side
	logic             aw_v_q, w_v_q;
	logic [31:0]      aw_a_q, w_d_q;
	logic [3:0]       w_s_q;
	logic             bvalid_q, rvalid_q;
	logic [1:0]       bresp_q, rresp_q;
	logic [31:0]      rdata_q;
	// Link side
	logic [2:0]       csn_s_q, sck_s_q, mosi_s_q; // Three-stage sync
	logic             csn_f_q, sck_f_q, mosi_f_q; // Agreed levels
	logic             csn_p_q, sck_p_q;           // Previous agreed levels
	logic [2:0]       bit_q;                      // Bit within byte
	logic [7:0]       tx_sh_q, rx_sh_q;           // Shifters
	logic             load_pend_q;                // Next byte wanted
	logic [CNT_W-1:0] rx_idx_q, tx_fet_q, tx_ld_q; // Byte counters
	// DMA side
	logic             req_q, we_q, wr_pend_q, hold_v_q;
	logic [31:0]      addr_q, wr_addr_q;
	logic [7:0]       wdat_q, wr_dat_q, hold_q;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	wire wr_fire  = aw_v_q && w_v_q && !bvalid_q;
	wire ar_fire  = s_axi_arvalid && !rvalid_q;
	wire wr_low   = wr_fire && w_s_q[0];
	wire acq_task = wr_low && hit(aw_a_q, OFS_ACQUIRE) && w_d_q[0];
	wire rel_task = wr_low && hit(aw_a_q, OFS_RELEASE) && w_d_q[0];
	logic [31:0] rd_mux;
	logic        rd_ok, wr_ok;
	// Register read mux; pointers readable at any time
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (hit(s_axi_araddr, OFS_EV_END))       rd_mux[0] = ev_end_q;
		else if (hit(s_axi_araddr, OFS_EV_FULL)) rd_mux[0] = ev_full_q;
		else if (hit(s_axi_araddr, OFS_EV_ACQ))  rd_mux[0] = ev_acq_q;
		else if (hit(s_axi_araddr, OFS_SHORTS))  rd_mux[SH_END_ACQ_BIT] = short_q;
		else if (hit(s_axi_araddr, OFS_SEM_ST))  rd_mux[1:0] = sem_q;
		else if (hit(s_axi_araddr, OFS_STATUS))  rd_mux[1:0] = {ovr_fl_q, ovr_rd_q};
		else if (hit(s_axi_araddr, OFS_ENABLE))  rd_mux[0] = enable_q;
		else if (hit(s_axi_araddr, OFS_RX_PTR))  rd_mux = rx_ptr_q;
		else if (hit(s_axi_araddr, OFS_RX_MAX))  rd_mux[CNT_W-1:0] = rx_max_q;
		else if (hit(s_axi_araddr, OFS_RX_AMT))  rd_mux[CNT_W-1:0] = rx_amt_q;
		else if (hit(s_axi_araddr, OFS_TX_PTR))  rd_mux = tx_ptr_q;
		else if (hit(s_axi_araddr, OFS_TX_MAX))  rd_mux[CNT_W-1:0] = tx_max_q;
		else if (hit(s_axi_araddr, OFS_TX_AMT))  rd_mux[CNT_W-1:0] = tx_amt_q;
		else if (hit(s_axi_araddr, OFS_CONFIG))  rd_mux[2:0] = cfg_q;
		else if (hit(s_axi_araddr, OFS_IGNF))    rd_mux[7:0] = ign_chr_q;
		else if (hit(s_axi_araddr, OFS_OVRF))    rd_mux[7:0] = ovr_chr_q;
		else if (!hit(s_axi_araddr, OFS_ACQUIRE) && !hit(s_axi_araddr, OFS_RELEASE))
			rd_ok = 1'b0;
	end
	// Write address mapped check, tasks included
	assign wr_ok = hit(aw_a_q, OFS_ACQUIRE) || hit(aw_a_q, OFS_RELEASE)
		|| hit(aw_a_q, OFS_EV_END) || hit(aw_a_q, OFS_EV_FULL) || hit(aw_a_q, OFS_EV_ACQ)
		|| hit(aw_a_q, OFS_SHORTS) || hit(aw_a_q, OFS_SEM_ST) || hit(aw_a_q, OFS_STATUS)
		|| hit(aw_a_q, OFS_ENABLE) || hit(aw_a_q, OFS_RX_PTR) || hit(aw_a_q, OFS_RX_MAX)
		|| hit(aw_a_q, OFS_RX_AMT) || hit(aw_a_q, OFS_TX_PTR) || hit(aw_a_q, OFS_TX_MAX)
		|| hit(aw_a_q, OFS_TX_AMT) || hit(aw_a_q, OFS_CONFIG) || hit(aw_a_q, OFS_IGNF)
		|| hit(aw_a_q, OFS_OVRF);
	assign s_axi_awready = !aw_v_q;
	assign s_axi_wready  = !w_v_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	// Bus handshakes; address and data taken in either order
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{aw_v_q, w_v_q, bvalid_q, rvalid_q} <= 4'h0;
			{aw_a_q, w_d_q, rdata_q} <= {3{RST_WORD}};
			w_s_q <= 4'h0;
			{bresp_q, rresp_q} <= {RESP_OKAY, RESP_OKAY};
		end else begin
			if (s_axi_awvalid && !aw_v_q) begin
				aw_v_q <= 1'b1;
				aw_a_q <= s_axi_awaddr;
			end else if (wr_fire) aw_v_q <= 1'b0;
			if (s_axi_wvalid && !w_v_q) begin
				w_v_q <= 1'b1;
				w_d_q <= s_axi_wdata;
				w_s_q <= s_axi_wstrb;
			end else if (wr_fire) w_v_q <= 1'b0;
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) bvalid_q <= 1'b0;
			if (ar_fire) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_mux;
				rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) rvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Pin synchronisers: a level counts once stages two and three agree
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{csn_s_q, sck_s_q, mosi_s_q} <= 9'h1c0;
			{csn_f_q, sck_f_q, mosi_f_q} <= 3'h4;
			{csn_p_q, sck_p_q} <= 2'h2;
		end else begin
			csn_s_q <= {csn_s_q[1:0], csn_n_i};
			sck_s_q <= {sck_s_q[1:0], sck_i};
			mosi_s_q <= {mosi_s_q[1:0], mosi_i};
			if (csn_s_q[1] == csn_s_q[2]) csn_f_q <= csn_s_q[2];
			if (sck_s_q[1] == sck_s_q[2]) sck_f_q <= sck_s_q[2];
			if (mosi_s_q[1] == mosi_s_q[2]) mosi_f_q <= mosi_s_q[2];
			csn_p_q <= csn_f_q;
			sck_p_q <= sck_f_q;
		end
	end

	// ---------------------------------------------------------------
	// Link edges and transaction decisions
	// ---------------------------------------------------------------
	wire lsb_first = cfg_q[CFG_ORDER_BIT];
	wire sck_edge  = sck_f_q != sck_p_q;
	wire lead_e    = sck_edge && (sck_f_q != cfg_q[CFG_CPOL_BIT]);
	wire sample_e  = cfg_q[CFG_CPHA_BIT] ? (sck_edge && !lead_e) : lead_e;
	wire cs_fall   = csn_p_q && !csn_f_q;
	wire cs_rise   = !csn_p_q && csn_f_q;
	wire active    = (xs_q == XS_GRANT) || (xs_q == XS_IGNORE);
	wire granted   = xs_q == XS_GRANT;
	wire start     = enable_q && cs_fall && (xs_q == XS_IDLE);
	wire take      = start && (sem_q == SEM_FREE) && !acq_task;
	wire en_rise   = enable_q && !en_prev_q;
	wire end_fire  = (xs_q == XS_DRAIN) && !req_q && !wr_pend_q;
	wire hand_cpu  = short_q || acq_pend_q || acq_task;
	wire acq_set   = enable_q && !en_rise && ((end_fire && hand_cpu)
		|| (!end_fire && acq_task && (sem_q != SEM_UNIT)));
	wire [7:0] rx_next = {rx_sh_q[6:0], mosi_f_q};
	wire byte_done = active && !cs_rise && sample_e && (bit_q == 3'h7);
	wire rx_store  = byte_done && granted && (rx_idx_q < rx_max_q);
	wire rx_drop   = byte_done && granted && (rx_idx_q >= rx_max_q);
	wire tx_exh    = tx_ld_q >= tx_max_q;
	wire load_go   = active && !cs_rise && load_pend_q
		&& ((xs_q == XS_IGNORE) || hold_v_q || tx_exh);
	wire use_hold  = load_go && granted && hold_v_q;
	wire use_orc   = load_go && granted && !hold_v_q;
	wire [7:0] load_b = !granted ? ign_chr_q : (hold_v_q ? hold_q : ovr_chr_q);
	wire fetch_ok  = granted && !hold_v_q && !req_q && !wr_pend_q && !rx_store
		&& (tx_fet_q < tx_max_q);

	assign miso_o    = tx_sh_q[7];
	assign miso_oe_o = enable_q && !csn_f_q;

	// Semaphore ownership
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sem_q      <= SEM_FREE;
			acq_pend_q <= 1'b0;
		end else if (!enable_q) begin
			sem_q      <= SEM_FREE;
			acq_pend_q <= 1'b0;
		end else if (en_rise) begin
			sem_q <= SEM_CPU;
		end else if (take) begin
			sem_q <= SEM_UNIT;
		end else if (end_fire) begin
			sem_q      <= hand_cpu ? SEM_CPU : SEM_FREE;
			acq_pend_q <= 1'b0;
		end else if (acq_task) begin
			if (sem_q == SEM_UNIT) acq_pend_q <= 1'b1;
			else sem_q <= SEM_CPU;
		end else if (rel_task && (sem_q == SEM_CPU)) begin
			sem_q <= SEM_FREE;
		end
	end

	// Transaction state, shifters and byte counters
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xs_q <= XS_IDLE;
			bit_q <= 3'h0;
			{tx_sh_q, rx_sh_q} <= {RST_CHAR, RST_CHAR};
			load_pend_q <= 1'b0;
			{rx_idx_q, tx_fet_q, tx_ld_q} <= '0;
		end else if (start) begin
			// Pointers reused as they stand on every start
			xs_q <= take ? XS_GRANT : XS_IGNORE;
			bit_q <= 3'h0;
			// First byte stands before the first sampling edge in every mode
			load_pend_q <= 1'b1;
			{rx_idx_q, tx_fet_q, tx_ld_q} <= '0;
		end else if (active && (cs_rise || !enable_q)) begin
			// Partial byte dropped, counter cleared
			xs_q <= granted ? XS_DRAIN : XS_IDLE;
			bit_q <= 3'h0;
			load_pend_q <= 1'b0;
		end else if (end_fire) begin
			xs_q <= XS_IDLE;
		end else if (active) begin
			if (sample_e) begin
				rx_sh_q <= rx_next;
				bit_q <= bit_q + 3'h1;
			end
			// Shift left after the sampling edge: the pin path lags about
			// half an SCK period, so the opposite edge would be too late
			if (byte_done) load_pend_q <= 1'b1;
			else if (sample_e) tx_sh_q <= {tx_sh_q[6:0], 1'b0};
			if (load_go) begin
				load_pend_q <= 1'b0;
				tx_sh_q <= lsb_first ? rev8(load_b) : load_b;
			end
			if (use_hold) tx_ld_q <= tx_ld_q + 1'b1;
			if (rx_store) rx_idx_q <= rx_idx_q + 1'b1;
			if (fetch_ok) tx_fet_q <= tx_fet_q + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// DMA: one byte port, receive writes ahead of transmit reads
	// ---------------------------------------------------------------
	assign mem_req_o   = req_q;
	assign mem_we_o    = we_q;
	assign mem_addr_o  = addr_q;
	assign mem_wdata_o = wdat_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{req_q, we_q, wr_pend_q, hold_v_q} <= 4'h0;
			{addr_q, wr_addr_q} <= {RST_WORD, RST_WORD};
			{wdat_q, wr_dat_q, hold_q} <= {3{RST_CHAR}};
		end else begin
			if (rx_store) begin
				wr_pend_q <= 1'b1;
				wr_addr_q <= rx_ptr_q + 32'(rx_idx_q);
				wr_dat_q  <= lsb_first ? rev8(rx_next) : rx_next;
			end
			if (req_q && mem_ack_i) begin
				req_q <= 1'b0;
				// Late read data after deselect is thrown away
				if (!we_q && granted) begin
					hold_q   <= mem_rdata_i;
					hold_v_q <= 1'b1;
				end
			end else if (!req_q && wr_pend_q) begin
				{req_q, we_q, wr_pend_q} <= 3'b110;
				addr_q <= wr_addr_q;
				wdat_q <= wr_dat_q;
			end else if (fetch_ok) begin
				{req_q, we_q} <= 2'b10;
				addr_q <= tx_ptr_q + 32'(tx_fet_q);
			end
			if (use_hold || !active) hold_v_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Software registers, events and sticky status (set beats clear)
	// ---------------------------------------------------------------
	wire wr_go = wr_fire && wr_ok;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{enable_q, en_prev_q, short_q} <= 3'h0;
			cfg_q <= 3'h0;
			{ign_chr_q, ovr_chr_q} <= {RST_CHAR, RST_CHAR};
			{rx_ptr_q, tx_ptr_q} <= {RST_WORD, RST_WORD};
			{rx_max_q, tx_max_q, rx_amt_q, tx_amt_q} <= '0;
			{ev_end_q, ev_full_q, ev_acq_q, ovr_rd_q, ovr_fl_q} <= 5'h0;
		end else begin
			en_prev_q <= enable_q;
			if (wr_go && w_s_q[0]) begin
				if (hit(aw_a_q, OFS_ENABLE)) enable_q <= w_d_q[0];
				if (hit(aw_a_q, OFS_SHORTS)) short_q <= w_d_q[SH_END_ACQ_BIT];
				if (hit(aw_a_q, OFS_CONFIG)) cfg_q <= w_d_q[2:0];
				if (hit(aw_a_q, OFS_IGNF)) ign_chr_q <= w_d_q[7:0];
				if (hit(aw_a_q, OFS_OVRF)) ovr_chr_q <= w_d_q[7:0];
			end
			if (wr_go && hit(aw_a_q, OFS_RX_PTR)) rx_ptr_q <= merge(rx_ptr_q, w_d_q, w_s_q);
			if (wr_go && hit(aw_a_q, OFS_TX_PTR)) tx_ptr_q <= merge(tx_ptr_q, w_d_q, w_s_q);
			if (wr_go && hit(aw_a_q, OFS_RX_MAX))
				rx_max_q <= CNT_W'(merge(32'(rx_max_q), w_d_q, w_s_q));
			if (wr_go && hit(aw_a_q, OFS_TX_MAX))
				tx_max_q <= CNT_W'(merge(32'(tx_max_q), w_d_q, w_s_q));
			if (end_fire) begin
				rx_amt_q <= rx_idx_q;
				tx_amt_q <= tx_ld_q;
			end
			// Events clear on a zero write
			if (end_fire) ev_end_q <= 1'b1;
			else if (wr_low && hit(aw_a_q, OFS_EV_END) && !w_d_q[0]) ev_end_q <= 1'b0;
			if (rx_store && (rx_idx_q + 1'b1 == rx_max_q)) ev_full_q <= 1'b1;
			else if (wr_low && hit(aw_a_q, OFS_EV_FULL) && !w_d_q[0]) ev_full_q <= 1'b0;
			if (acq_set) ev_acq_q <= 1'b1;
			else if (wr_low && hit(aw_a_q, OFS_EV_ACQ) && !w_d_q[0]) ev_acq_q <= 1'b0;
			// Status flags clear on a one write
			if (use_orc) ovr_rd_q <= 1'b1;
			else if (wr_low && hit(aw_a_q, OFS_STATUS) && w_d_q[ST_EXHAUST_BIT])
				ovr_rd_q <= 1'b0;
			if (rx_drop) ovr_fl_q <= 1'b1;
			else if (wr_low && hit(aw_a_q, OFS_STATUS) && w_d_q[ST_OVERFLOW_BIT])
				ovr_fl_q <= 1'b0;
		end
	end
endmodule : ssds_top

// file: ssds_pkg.sv
/*
 * Shared constants for the SPI target unit: register offsets, field
 * positions, reset values and state encodings.
 * Assumes a 12-bit register window decoded from the bus address.
 */
package ssds_pkg;
	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_ACQUIRE = 12'h024; // Acquire task
	localparam logic [11:0] OFS_RELEASE = 12'h028; // Release task
	localparam logic [11:0] OFS_EV_END  = 12'h104; // Transaction complete event
	localparam logic [11:0] OFS_EV_FULL = 12'h110; // Receive buffer full event
	localparam logic [11:0] OFS_EV_ACQ  = 12'h128; // Semaphore acquired event
	localparam logic [11:0] OFS_SHORTS  = 12'h200; // Shortcut control
	localparam logic [11:0] OFS_SEM_ST  = 12'h400; // Semaphore state
	localparam logic [11:0] OFS_STATUS  = 12'h440; // Sticky status flags
	localparam logic [11:0] OFS_ENABLE  = 12'h500; // Unit enable
	localparam logic [11:0] OFS_RX_PTR  = 12'h534; // Receive buffer pointer
	localparam logic [11:0] OFS_RX_MAX  = 12'h538; // Receive max count
	localparam logic [11:0] OFS_RX_AMT  = 12'h53c; // Received byte count
	localparam logic [11:0] OFS_TX_PTR  = 12'h544; // Transmit buffer pointer
	localparam logic [11:0] OFS_TX_MAX  = 12'h548; // Transmit max count
	localparam logic [11:0] OFS_TX_AMT  = 12'h54c; // Transmitted byte count
	localparam logic [11:0] OFS_CONFIG  = 12'h554; // Mode and bit order
	localparam logic [11:0] OFS_IGNF    = 12'h55c; // Ignored fill character
	localparam logic [11:0] OFS_OVRF    = 12'h5c0; // Overrun fill character
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int CFG_ORDER_BIT   = 0; // 1 = lsb first
	localparam int CFG_CPHA_BIT    = 1; // Clock phase
	localparam int CFG_CPOL_BIT    = 2; // Clock polarity
	localparam int ST_EXHAUST_BIT  = 0; // Transmit exhausted flag
	localparam int ST_OVERFLOW_BIT = 1; // Receive overflow flag
	localparam int SH_END_ACQ_BIT  = 2; // Completion-to-acquire shortcut
	localparam logic [31:0] RST_WORD = 32'h0000_0000; // Pointers, addresses, bus words
	localparam logic [7:0]  RST_CHAR = 8'h00;         // Fill characters
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SEM_FREE = 2'h0,
		SEM_CPU  = 2'h1,
		SEM_UNIT = 2'h2
	} ssds_sem_e;
	typedef enum logic [3:0] {
		XS_IDLE   = 4'b0001,
		XS_GRANT  = 4'b0010,
		XS_IGNORE = 4'b0100,
		XS_DRAIN  = 4'b1000
	} ssds_xfer_e;
endpackage : ssds_pkg

// file: ssds_assertions.sv
/* Port checker for ssds_top, bound to every instance.
 * Assumes one sys_clk domain and the async active-low reset. */
`timescale 1ns/100ps
module ssds_assertions (
	// Clock, reset, bus handshakes
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// SPI pins and RAM port
	input wire logic        csn_n_i,
	input wire logic        miso_oe_o,
	input wire logic        mem_req_o,
	input wire logic        mem_we_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic        mem_ack_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Bus never held off by the semaphore
	wr_resp_a: assert property (s_axi_awvalid && s_axi_wvalid |-> ##[1:4] s_axi_bvalid)
		else $error("write not answered");
	rd_resp_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
		else $error("read not answered");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	// Three-flop sync plus a register, so six cycles suffice
	miso_hiz_a: assert property (csn_n_i [*6] |-> !miso_oe_o)
		else $error("miso driven while deselected");
	// A RAM request may not wander before its ack
	mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_we_o))
		else $error("ram request dropped early");
	mem_addr_a: assert property (mem_req_o && !mem_ack_i |=> $stable(mem_addr_o))
		else $error("ram address moved");
	idle_ram_a: assert property (csn_n_i [*8] |-> !$rose(mem_req_o))
		else $error("ram access begun while deselected");
	cover property (mem_req_o && mem_we_o && mem_ack_i);
	cover property (mem_req_o && !mem_we_o && mem_ack_i);
	cover property ($rose(miso_oe_o));
endmodule : ssds_assertions
bind ssds_top ssds_assertions chk_u (.sys_clk_i, .rst_n_i, .s_axi_awvalid, .s_axi_wvalid,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .csn_n_i,
	.miso_oe_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i);

// file: ssds_spi_master.sv
/* Behavioural SPI master driving the target unit, 32 ns SCK.
 * Assumes the bench fills tx_b and reads rx_b around xfer. */
`timescale 1ns/100ps
module ssds_spi_master (
	input  wire logic miso_i,
	output logic      csn_n_o,
	output logic      sck_o,
	output logic      mosi_o
);
	logic [7:0] tx_b [4]; // Bytes to send
	logic [7:0] rx_b [4]; // Bytes seen on MISO
	initial begin
		csn_n_o = 1'b1;
		sck_o = 1'b0;
		mosi_o = 1'b0;
	end
	// One frame; cfg is {cpol, cpha, lsb first}; SCK idles between frames
	task automatic xfer(input logic [2:0] cfg, input int nbits);
		int k;
		int j;
		// Pins move 1 ns after a sys_clk edge, never on it
		#1 sck_o = cfg[2];
		#40 csn_n_o = 1'b0;
		#200;
		for (int i = 0; i < nbits; i++) begin
			k = i / 8;
			j = cfg[0] ? i % 8 : 7 - i % 8;
			if (!cfg[1]) mosi_o = tx_b[k][j];
			#16 sck_o = ~cfg[2];
			if (cfg[1]) mosi_o = tx_b[k][j];
			else rx_b[k][j] = miso_i;
			#16 sck_o = cfg[2];
			if (cfg[1]) rx_b[k][j] = miso_i;
		end
		#100 csn_n_o = 1'b1;
		mosi_o = ~mosi_o; // Released line shows no stale bit
		#200;
	endtask : xfer
endmodule : ssds_spi_master

// file: tb.sv
/* Self-checking bench for ssds_top with byte RAM and SPI master model.
 * Assumes the checker is bound and the master model is compiled first. */
`timescale 1ns/100ps
module tb;
	import ssds_pkg::*;
	logic sys_clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, mem_ack_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, miso_o, miso_oe_o, mem_req_o, mem_we_o, csn_n_i, sck_i, mosi_i;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, mem_addr_o, q, seed;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  mem_wdata_o, ram [256];
	int          err_count, n_checks, cyc;
	wire         miso_w = miso_oe_o ? miso_o : 1'bz; // Undriven when deselected
	ssds_top dut_u (.sys_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .csn_n_i, .sck_i, .mosi_i, .miso_o,
		.miso_oe_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
		.mem_rdata_i(ram[mem_addr_o[7:0]]), .mem_ack_i);
	ssds_spi_master m_u (.miso_i(miso_w), .csn_n_o(csn_n_i), .sck_o(sck_i), .mosi_o(mosi_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// RAM answers every other cycle so the DMA sees stalls; also the hang limit
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		mem_ack_i <= mem_req_o && !mem_ack_i && cyc[0];
		if (mem_req_o && mem_ack_i && mem_we_o) ram[mem_addr_o[7:0]] <= mem_wdata_o;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// Byte expected on MISO: buffer bytes, then the overrun fill
	function automatic logic [31:0] exp_tx(input int k);
		return k < 2 ? 32'(ram[128 + k]) : 32'ha5;
	endfunction : exp_tx
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One AXI4-Lite write or read; every channel held until its handshake
	task automatic bus(input bit we, input logic [11:0] a, input logic [31:0] d);
		bit pa;
		bit pw;
		bit pb;
		pa = 1;
		pw = we;
		pb = 1;
		@(posedge sys_clk_i);
		s_axi_awaddr <= {20'h0, a};
		s_axi_araddr <= {20'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= we;
		s_axi_wvalid <= we;
		s_axi_arvalid <= !we;
		s_axi_bready <= we;
		s_axi_rready <= !we;
		while (pa || pw || pb) begin
			@(posedge sys_clk_i);
			if (pa && (we ? s_axi_awready : s_axi_arready)) begin
				pa = 0;
				s_axi_awvalid <= 0;
				s_axi_arvalid <= 0;
			end
			if (pw && s_axi_wready) begin
				pw = 0;
				s_axi_wvalid <= 0;
			end
			if (pb && (we ? s_axi_bvalid : s_axi_rvalid)) begin
				pb = 0;
				q = s_axi_rdata;
				resp_q = we ? s_axi_bresp : s_axi_rresp;
				s_axi_bready <= 0;
				s_axi_rready <= 0;
			end
		end
	endtask : bus
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(q, e);
	endtask : rc
	task automatic results();
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		mem_ack_i = 0;
		rst_n_i = 0;
		seed = 32'h69ccc0d6;
		foreach (ram[i]) begin
			seed = xs(seed);
			ram[i] = seed[7:0];
		end
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1;
		bus(1, OFS_ENABLE, 1);
		rc(OFS_SEM_ST, 1);
		rc(OFS_EV_ACQ, 0);
		bus(1, OFS_ACQUIRE, 1);
		rc(OFS_EV_ACQ, 1);
		bus(1, OFS_EV_ACQ, 0);
		bus(0, 12'h7fc, 0);
		chk({resp_q, q[29:0]}, {RESP_SLVERR, 30'h0});
		bus(1, OFS_RX_PTR, 32'h40);
		bus(1, OFS_RX_MAX, 3);
		bus(1, OFS_TX_PTR, 32'h80);
		bus(1, OFS_TX_MAX, 2);
		bus(1, OFS_OVRF, 32'ha5);
		bus(1, OFS_IGNF, 32'h3c);
		rc(OFS_RX_PTR, 32'h40);
		bus(1, OFS_RELEASE, 1);
		bus(1, OFS_RELEASE, 1);
		rc(OFS_SEM_ST, 0);
		// Every CONFIG value, four bytes against limits of three and two
		for (int m = 0; m < 8; m++) begin
			bus(1, OFS_CONFIG, m);
			for (int k = 0; k < 4; k++) begin
				seed = xs(seed);
				m_u.tx_b[k] = seed[7:0];
			end
			ram[67] = 8'h5a;
			m_u.xfer(m[2:0], 32);
			for (int k = 0; k < 4; k++) chk(32'(m_u.rx_b[k]), exp_tx(k));
			for (int k = 0; k < 3; k++) chk(32'(ram[64 + k]), 32'(m_u.tx_b[k]));
			chk(32'(ram[67]), 32'h5a);
			rc(OFS_STATUS, 3);
			rc(OFS_RX_AMT, 3);
			rc(OFS_TX_AMT, 2);
			rc(OFS_EV_END, 1);
			rc(OFS_EV_FULL, 1);
			rc(OFS_SEM_ST, 0);
			bus(1, OFS_STATUS, 3);
			bus(1, OFS_EV_END, 0);
			bus(1, OFS_EV_FULL, 0);
		end
		bus(1, OFS_SHORTS, 4);
		m_u.xfer(3'h0, 12);
		rc(OFS_RX_AMT, 1);
		rc(OFS_SEM_ST, 1);
		rc(OFS_EV_ACQ, 1);
		bus(1, OFS_EV_ACQ, 0);
		bus(1, OFS_EV_END, 0);
		ram[64] = 8'h11;
		m_u.xfer(3'h0, 16);
		for (int k = 0; k < 2; k++) chk(32'(m_u.rx_b[k]), 32'h3c);
		chk(32'(ram[64]), 32'h11);
		rc(OFS_EV_END, 0);
		bus(1, OFS_RELEASE, 1);
		fork
			m_u.xfer(3'h0, 16);
			begin
				repeat (150) @(posedge sys_clk_i);
				bus(1, OFS_ACQUIRE, 1);
				rc(OFS_SEM_ST, 2);
				rc(OFS_EV_ACQ, 0);
			end
		join
		rc(OFS_SEM_ST, 1);
		rc(OFS_EV_ACQ, 1);
		bus(1, OFS_EV_ACQ, 0);
		repeat (8) @(posedge sys_clk_i);
		rc(OFS_EV_ACQ, 0);
		results();
	end
endmodule : tb
